// ---- hdl/dcsync_top.sv ----
// Sync output unit: activation, start time, cyclic pulses and status
`timescale 1ns/1ps
module dcsync_top (
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire dcsync_pkg::dcsync_bus_s  net_bus,
  input  wire dcsync_pkg::dcsync_bus_s  host_bus,
  output logic [7:0]                    net_rdata,
  output logic [7:0]                    host_rdata,
  input  wire logic                     owner_host,
  input  wire logic                     write_ack_en,
  input  wire logic                     frame_end,
  input  wire logic [63:0]              sys_time,
  input  wire logic [15:0]              cfg_len,
  input  wire logic                     cfg_len_load,
  output logic [1:0]                    sync_out,
  output logic [1:0]                    app_evt_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [6:0]  ctl_q;
  logic [6:0]  ctl_d;
  logic [15:0] len_q;
  logic [63:0] next0_q;
  logic [63:0] next1_q;
  logic [31:0] cyc0_q;
  logic [31:0] cyc1_q;
  logic        lo_wr_q;
  logic        hi_wr_q;
  logic        run0_q;
  logic        imm_q;
  logic        arm1_q;
  logic [1:0]  pend_q;
  logic        plaus_q;
  logic [1:0]  evt_q;
  logic [7:0]  net_rdata_q;
  logic [7:0]  host_rdata_q;

  logic        own_wr;
  logic [15:0] own_addr;
  logic [7:0]  own_wdata;
  logic        wr_act;
  logic        wr_start;
  logic        wr_cyc0;
  logic        wr_cyc1;
  logic        commit;
  logic        fill_hi;
  logic [31:0] fill_upper;
  logic [63:0] start_eff;
  logic        auto_set;
  logic        act_rise;
  logic        dbg;
  logic [63:0] diff;
  logic        out_near;
  logic        due0;
  logic        due1;
  logic [63:0] base0;
  logic [1:0]  fire;
  logic [1:0]  clr;

  ////////////////////////////////////////////////////////////////////////////
  // Write path: only the owning side reaches configuration
  assign own_wr    = owner_host ? host_bus.wr : net_bus.wr;
  assign own_addr  = owner_host ? host_bus.addr : net_bus.addr;
  assign own_wdata = owner_host ? host_bus.wdata : net_bus.wdata;

  assign wr_act   = own_wr && own_addr == dcsync_pkg::ADDR_ACT;
  assign wr_start = own_wr && !ctl_q[dcsync_pkg::ACT_RUN] &&
                    own_addr[15:3] == dcsync_pkg::ADDR_START[15:3];
  assign wr_cyc0  = own_wr &&
                    own_addr[15:2] == dcsync_pkg::ADDR_CYC0[15:2];
  assign wr_cyc1  = own_wr &&
                    own_addr[15:2] == dcsync_pkg::ADDR_CYC1[15:2];
  assign dbg      = wr_act && own_wdata[dcsync_pkg::ACT_DBG];

  ////////////////////////////////////////////////////////////////////////////
  // Start time commit at end of frame
  assign commit  = frame_end && (lo_wr_q || hi_wr_q);
  assign fill_hi = lo_wr_q && !hi_wr_q &&
                   (ctl_q[dcsync_pkg::ACT_EXT] ||
                    ctl_q[dcsync_pkg::ACT_AUTO]);
  // Upper half chosen so the start lands at or after now
  assign fill_upper = sys_time[63:32] +
                      {31'h0, next0_q[31:0] < sys_time[31:0]};
  assign start_eff  = (commit && fill_hi) ?
                      {fill_upper, next0_q[31:0]} : next0_q;
  assign auto_set   = commit && ctl_q[dcsync_pkg::ACT_AUTO];

  always_ff @(posedge clock) begin
    if (reset) begin
      lo_wr_q <= 1'b0;
      hi_wr_q <= 1'b0;
    end else if (wr_start) begin
      if (own_addr[2]) begin
        hi_wr_q <= 1'b1;
      end else begin
        lo_wr_q <= 1'b1;
      end
    end else if (frame_end) begin
      lo_wr_q <= 1'b0;
      hi_wr_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activation register
  always_comb begin
    ctl_d = ctl_q;
    if (wr_act) begin
      ctl_d = own_wdata[6:0];
    end
    if (auto_set) begin
      ctl_d[dcsync_pkg::ACT_RUN] = 1'b1;
    end
  end

  assign act_rise = ctl_d[dcsync_pkg::ACT_RUN] &&
                    !ctl_q[dcsync_pkg::ACT_RUN];

  always_ff @(posedge clock) begin
    if (reset) begin
      ctl_q <= dcsync_pkg::CTL_RST;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plausibility of the start time against the near-future window
  assign diff     = start_eff - sys_time;
  assign out_near = ctl_d[dcsync_pkg::ACT_NEAR] ?
                    (|diff[dcsync_pkg::NEAR_LONG_BIT:
                           dcsync_pkg::NEAR_SHORT_BIT]) :
                    diff[dcsync_pkg::NEAR_LONG_BIT];

  always_ff @(posedge clock) begin
    if (reset) begin
      plaus_q <= 1'b0;
    end else if (act_rise) begin
      plaus_q <= out_near;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cyclic scheduling
  // Unsigned compare: a start behind the time fires on the next clock
  assign due0  = ctl_q[dcsync_pkg::ACT_RUN] && run0_q &&
                 (imm_q || sys_time >= next0_q);
  assign due1  = ctl_q[dcsync_pkg::ACT_RUN] && arm1_q &&
                 sys_time >= next1_q;
  assign base0 = imm_q ? sys_time : next0_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      run0_q <= 1'b0;
      imm_q  <= 1'b0;
      arm1_q <= 1'b0;
      pend_q <= 2'b00;
    end else if (!ctl_d[dcsync_pkg::ACT_RUN]) begin
      run0_q <= 1'b0;
      imm_q  <= 1'b0;
      arm1_q <= 1'b0;
      pend_q <= 2'b00;
    end else if (act_rise) begin
      run0_q <= 1'b1;
      imm_q  <= ctl_d[dcsync_pkg::ACT_CHK] && out_near;
      arm1_q <= 1'b0;
      pend_q <= {ctl_d[dcsync_pkg::ACT_EN1],
                 ctl_d[dcsync_pkg::ACT_EN0]};
    end else begin
      if (due1) begin
        arm1_q    <= 1'b0;
        pend_q[1] <= 1'b0;
      end
      if (due0) begin
        run0_q    <= cyc0_q != dcsync_pkg::CYC_RST;
        imm_q     <= 1'b0;
        arm1_q    <= 1'b1;
        pend_q[0] <= 1'b0;
      end
    end
  end

  // Start time store doubles as next primary pulse time
  always_ff @(posedge clock) begin
    if (reset) begin
      next0_q <= dcsync_pkg::TIME_RST;
    end else if (wr_start) begin
      next0_q[{own_addr[2:0], 3'b000} +: 8] <= own_wdata;
    end else if (commit && fill_hi) begin
      next0_q[63:32] <= fill_upper;
    end else if (due0) begin
      next0_q <= base0 + {32'h0, cyc0_q};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      next1_q <= dcsync_pkg::TIME_RST;
    end else if (due0) begin
      next1_q <= base0 + {32'h0, cyc1_q};
    end else if (due1) begin
      // Once fired, the readout moves on to the slot after the next primary
      next1_q <= next0_q + {32'h0, cyc1_q};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cyc0_q <= dcsync_pkg::CYC_RST;
    end else if (wr_cyc0) begin
      cyc0_q[{own_addr[1:0], 3'b000} +: 8] <= own_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cyc1_q <= dcsync_pkg::CYC_RST;
    end else if (wr_cyc1) begin
      cyc1_q[{own_addr[1:0], 3'b000} +: 8] <= own_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      len_q <= dcsync_pkg::LEN_RST;
    end else if (cfg_len_load) begin
      len_q <= cfg_len;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse generation and event requests
  // Debug pulse follows the enables being written with it
  assign fire[0] = (due0 && ctl_q[dcsync_pkg::ACT_EN0]) ||
                   (dbg && ctl_d[dcsync_pkg::ACT_EN0]);
  assign fire[1] = (due1 && ctl_q[dcsync_pkg::ACT_EN1]) ||
                   (dbg && ctl_d[dcsync_pkg::ACT_EN1]);

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      localparam logic [15:0] STAT_ADDR =
        (ch == 0) ? dcsync_pkg::ADDR_STAT0 : dcsync_pkg::ADDR_STAT1;

      // Network reads never acknowledge
      assign clr[ch] = host_bus.addr == STAT_ADDR &&
                       ((host_bus.rd && !write_ack_en) ||
                        (host_bus.wr && write_ack_en));

      always_ff @(posedge clock) begin
        if (reset) begin
          evt_q[ch] <= 1'b0;
        end else begin
          evt_q[ch] <= fire[ch] || (evt_q[ch] && !clr[ch]);
        end
      end

      dcsync_pulse u_pulse (
        .clock (clock),
        .reset (reset),
        .fire  (fire[ch]),
        .clear (clr[ch]),
        .len   (len_q),
        .pulse (sync_out[ch])
      );
    end
  endgenerate

  assign app_evt_req = evt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read path, one clock latency, unmapped bytes read zero
  function automatic logic [7:0] rd_byte(input logic [15:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == dcsync_pkg::ADDR_ACT) begin
      v = {1'b0, ctl_q};
    end else if (a == dcsync_pkg::ADDR_LEN_LO) begin
      v = len_q[7:0];
    end else if (a == dcsync_pkg::ADDR_LEN_HI) begin
      v = len_q[15:8];
    end else if (a == dcsync_pkg::ADDR_ACT_STAT) begin
      v = {5'h00, plaus_q, pend_q};
    end else if (a == dcsync_pkg::ADDR_STAT0) begin
      v = {7'h00, pend_q[0]};
    end else if (a == dcsync_pkg::ADDR_STAT1) begin
      v = {7'h00, pend_q[1]};
    end else if (a[15:3] == dcsync_pkg::ADDR_START[15:3]) begin
      v = next0_q[{a[2:0], 3'b000} +: 8];
    end else if (a[15:3] == dcsync_pkg::ADDR_NEXT1[15:3]) begin
      v = next1_q[{a[2:0], 3'b000} +: 8];
    end else if (a[15:2] == dcsync_pkg::ADDR_CYC0[15:2]) begin
      v = cyc0_q[{a[1:0], 3'b000} +: 8];
    end else if (a[15:2] == dcsync_pkg::ADDR_CYC1[15:2]) begin
      v = cyc1_q[{a[1:0], 3'b000} +: 8];
    end
    return v;
  endfunction

  always_ff @(posedge clock) begin
    if (reset) begin
      net_rdata_q <= 8'h00;
    end else if (net_bus.rd) begin
      net_rdata_q <= rd_byte(net_bus.addr);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      host_rdata_q <= 8'h00;
    end else if (host_bus.rd) begin
      host_rdata_q <= rd_byte(host_bus.addr);
    end
  end

  assign net_rdata  = net_rdata_q;
  assign host_rdata = host_rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence s_prim_due;
    ctl_q[dcsync_pkg::ACT_RUN] && run0_q && !imm_q &&
      sys_time >= next0_q;
  endsequence

  sequence s_start_locked_wr;
    ctl_q[dcsync_pkg::ACT_RUN] && own_wr && !due0 &&
      own_addr[15:3] == dcsync_pkg::ADDR_START[15:3];
  endsequence

  chk_prim_advance: assert property (
    s_prim_due ##0 (cyc0_q != 32'h0) |=>
      next0_q == $past(next0_q) + {32'h0, $past(cyc0_q)})
    else $error("next primary time did not advance by cycle time");

  chk_single_shot: assert property (
    s_prim_due ##0 (cyc0_q == 32'h0) ##1 ctl_q[dcsync_pkg::ACT_RUN] |->
      !due0 [*3])
    else $error("single shot produced a second primary pulse");

  chk_idle_unit: assert property (
    !ctl_d[dcsync_pkg::ACT_RUN] |=>
      !run0_q && !arm1_q && pend_q == 2'b00)
    else $error("schedule kept while unit deactivated");

  chk_prim_gate: assert property (
    fire[0] |-> ctl_q[dcsync_pkg::ACT_EN0] ||
      (dbg && ctl_d[dcsync_pkg::ACT_EN0]))
    else $error("primary pulse without enable");

  chk_sec_gate: assert property (
    fire[1] |-> ctl_q[dcsync_pkg::ACT_EN1] ||
      (dbg && ctl_d[dcsync_pkg::ACT_EN1]))
    else $error("secondary pulse without enable");

  chk_auto_act: assert property (
    auto_set && !(wr_act && !own_wdata[dcsync_pkg::ACT_RUN]) |=>
      ctl_q[dcsync_pkg::ACT_RUN])
    else $error("auto-activation did not set activation");

  chk_dbg_reads: assert property (
    net_bus.rd && net_bus.addr == dcsync_pkg::ADDR_ACT |=>
      !net_rdata[dcsync_pkg::ACT_DBG])
    else $error("debug bit read back as one");

  chk_owner_write: assert property (
    owner_host && !host_bus.wr && net_bus.wr &&
      net_bus.addr[15:2] == dcsync_pkg::ADDR_CYC0[15:2] |=>
      $stable(cyc0_q))
    else $error("non-owner write changed primary cycle time");

  chk_start_lock: assert property (
    s_start_locked_wr |=> $stable(next0_q))
    else $error("start time changed while unit active");

  chk_evt_set: assert property (
    fire[0] |=> app_evt_req[0])
    else $error("primary pulse did not raise event request");

  chk_pend_clear: assert property (
    due0 && !act_rise && ctl_d[dcsync_pkg::ACT_RUN] |=> !pend_q[0])
    else $error("pending flag kept after first primary pulse");

endmodule

// ---- hdl/dcsync_pkg.sv ----
// Package: register map, field positions and timing of the sync output unit
package dcsync_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [15:0] ADDR_ACT      = 16'h0981;
  localparam logic [15:0] ADDR_LEN_LO   = 16'h0982;
  localparam logic [15:0] ADDR_LEN_HI   = 16'h0983;
  localparam logic [15:0] ADDR_ACT_STAT = 16'h0984;
  localparam logic [15:0] ADDR_STAT0    = 16'h098e;
  localparam logic [15:0] ADDR_STAT1    = 16'h098f;
  localparam logic [15:0] ADDR_START    = 16'h0990;
  localparam logic [15:0] ADDR_NEXT1    = 16'h0998;
  localparam logic [15:0] ADDR_CYC0     = 16'h09a0;
  localparam logic [15:0] ADDR_CYC1     = 16'h09a4;

  ////////////////////////////////////////////////////////////////////////////
  // Activation register fields
  localparam int ACT_RUN  = 0;
  localparam int ACT_EN0  = 1;
  localparam int ACT_EN1  = 2;
  localparam int ACT_AUTO = 3;
  localparam int ACT_EXT  = 4;
  localparam int ACT_CHK  = 5;
  localparam int ACT_NEAR = 6;
  localparam int ACT_DBG  = 7;

  // Activation status fields
  localparam int ST_PEND0 = 0;
  localparam int ST_PEND1 = 1;
  localparam int ST_PLAUS = 2;

  // Near-future window top bits
  localparam int NEAR_SHORT_BIT = 31;
  localparam int NEAR_LONG_BIT  = 63;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [6:0]  CTL_RST  = 7'h00;
  localparam logic [15:0] LEN_RST  = 16'h0000;
  localparam logic [63:0] TIME_RST = 64'h0;
  localparam logic [31:0] CYC_RST  = 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ       = 125;
  localparam int CLK_NS        = 1000 / CLK_MHZ;
  localparam int PULSE_UNIT_NS = 10;
  localparam int REM_W         = 20;

  // One byte access on either register port
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } dcsync_bus_s;

endpackage

// ---- hdl/dcsync_pulse.sv ----
// Pulse shaper: timed pulse or acknowledge-held level for one sync output
`timescale 1ns/1ps
module dcsync_pulse (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        fire,
  input  wire logic        clear,
  input  wire logic [15:0] len,
  output logic             pulse
);
  localparam logic [dcsync_pkg::REM_W-1:0] STEP =
    dcsync_pkg::REM_W'(dcsync_pkg::CLK_NS);
  localparam logic [dcsync_pkg::REM_W-1:0] UNIT =
    dcsync_pkg::REM_W'(dcsync_pkg::PULSE_UNIT_NS);

  logic [dcsync_pkg::REM_W-1:0] rem_q;

  // Remaining time kept in ns so the 10 ns unit rounds up to whole clocks
  always_ff @(posedge clock) begin
    if (reset) begin
      pulse <= 1'b0;
      rem_q <= '0;
    end else if (fire) begin
      pulse <= 1'b1;
      rem_q <= dcsync_pkg::REM_W'(len) * UNIT;
    end else if (pulse && len != 16'h0000) begin
      if (rem_q <= STEP) begin
        pulse <= 1'b0;
      end else begin
        rem_q <= rem_q - STEP;
      end
    end else if (pulse && clear) begin
      pulse <= 1'b0;
    end
  end
endmodule

// ---- verification/dcsync_far.sv ----
// Far-side model: network master, host processor and system time source
`timescale 1ns/1ps
module dcsync_far (
  input  wire logic                    clock,
  input  wire logic [7:0]              net_rdata,
  input  wire logic [7:0]              host_rdata,
  output dcsync_pkg::dcsync_bus_s      net_bus,
  output dcsync_pkg::dcsync_bus_s      host_bus,
  output logic                         frame_end,
  output logic [63:0]                  sys_time
);
  initial begin
    net_bus = '0;
    host_bus = '0;
    frame_end = 1'b0;
    sys_time = 64'h0;
  end

  // System time in ns advances one clock period per edge
  always @(posedge clock) begin
    sys_time <= sys_time + 64'(dcsync_pkg::CLK_NS);
  end

  ////////////////////////////////////////////////////////////////////////////
  // One byte access; the request stands for exactly one edge, then the
  // idle bus carries inverted address and data so nothing stale is reused
  task automatic access(input bit host, input bit wr, input logic [15:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    dcsync_pkg::dcsync_bus_s b;
    dcsync_pkg::dcsync_bus_s idle;
    b = '{rd: !wr, wr: wr, addr: a, wdata: d};
    idle = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    @(posedge clock);
    if (host) begin
      host_bus <= b;
    end else begin
      net_bus <= b;
    end
    @(posedge clock);
    host_bus <= host ? idle : host_bus;
    net_bus <= host ? net_bus : idle;
    #1;
    q = host ? host_rdata : net_rdata;
  endtask

  // Multibyte registers are little endian
  task automatic wr_n(input bit host, input logic [15:0] a,
                      input logic [63:0] v, input int n);
    logic [7:0] q;
    for (int i = 0; i < n; i++) begin
      access(host, 1'b1, a + 16'(i), v[8*i +: 8], q);
    end
  endtask

  task automatic rd_n(input bit host, input logic [15:0] a, input int n,
                      output logic [63:0] v);
    logic [7:0] q;
    v = '0;
    for (int i = 0; i < n; i++) begin
      access(host, 1'b0, a + 16'(i), 8'h00, q);
      v[8*i +: 8] = q;
    end
  endtask

  // Frame boundary commits pending start time bytes
  task automatic frame();
    @(posedge clock);
    frame_end <= 1'b1;
    @(posedge clock);
    frame_end <= 1'b0;
  endtask
endmodule

// ---- verification/dc_sync_pulse_generator_tb.sv ----
// Self-checking testbench of the sync output unit
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
      n_fail++; \
      $display("BAD %0t got %0h exp %0h", $time, (g), (e)); \
    end \
  end
module dc_sync_pulse_generator_tb;
  logic                    clock;
  logic                    reset;
  dcsync_pkg::dcsync_bus_s net_bus;
  dcsync_pkg::dcsync_bus_s host_bus;
  logic [7:0]              net_rdata;
  logic [7:0]              host_rdata;
  logic                    owner_host;
  logic                    write_ack_en;
  logic                    frame_end;
  logic [63:0]             sys_time;
  logic [15:0]             cfg_len;
  logic                    cfg_len_load;
  logic [1:0]              sync_out;
  logic [1:0]              app_evt_req;
  int                      n_fail;
  int                      cmp_count;
  int unsigned             cyc;
  int unsigned             rise_cnt [2];
  int unsigned             last_rise [2];
  int unsigned             prev_rise [2];
  int unsigned             run_len [2];
  int unsigned             last_run [2];

  localparam logic [15:0] RST_A [8] = '{dcsync_pkg::ADDR_ACT,
    dcsync_pkg::ADDR_LEN_LO, dcsync_pkg::ADDR_ACT_STAT,
    dcsync_pkg::ADDR_STAT0, dcsync_pkg::ADDR_START,
    dcsync_pkg::ADDR_NEXT1, dcsync_pkg::ADDR_CYC0, 16'h0988};
  localparam int RST_N [8] = '{1, 2, 1, 1, 8, 8, 4, 1};

  dcsync_top dcsync_top_i (
    .clock        (clock),
    .reset        (reset),
    .net_bus      (net_bus),
    .host_bus     (host_bus),
    .net_rdata    (net_rdata),
    .host_rdata   (host_rdata),
    .owner_host   (owner_host),
    .write_ack_en (write_ack_en),
    .frame_end    (frame_end),
    .sys_time     (sys_time),
    .cfg_len      (cfg_len),
    .cfg_len_load (cfg_len_load),
    .sync_out     (sync_out),
    .app_evt_req  (app_evt_req)
  );

  dcsync_far dcsync_far_i (
    .clock      (clock),
    .net_rdata  (net_rdata),
    .host_rdata (host_rdata),
    .net_bus    (net_bus),
    .host_bus   (host_bus),
    .frame_end  (frame_end),
    .sys_time   (sys_time)
  );

  initial begin
    clock = 1'b0;
  end
  always #4 clock = ~clock;

  // Pulse monitor: rising edges, their cycle and the length of each run
  always @(posedge clock) begin
    cyc++;
    for (int k = 0; k < 2; k++) begin
      if (sync_out[k] === 1'b1) begin
        if (run_len[k] == 0) begin
          rise_cnt[k]++;
          prev_rise[k] = last_rise[k];
          last_rise[k] = cyc;
        end
        run_len[k]++;
      end else begin
        if (run_len[k] != 0) begin
          last_run[k] = run_len[k];
        end
        run_len[k] = 0;
      end
    end
  end

  // Cycles a pulse of len units of 10 ns stays high
  function automatic int unsigned exp_run(input logic [15:0] len);
    return (int'(len) * dcsync_pkg::PULSE_UNIT_NS + dcsync_pkg::CLK_NS - 1)
           / dcsync_pkg::CLK_NS;
  endfunction

  task automatic wait_rise(input int k, input int unsigned n);
    int t;
    t = 0;
    while (rise_cnt[k] < n && t < 1000) begin
      @(posedge clock);
      #1;
      t++;
    end
    if (rise_cnt[k] < n) begin
      n_fail++;
      $display("BAD %0t no sync pulse", $time);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [63:0] v;
    logic [63:0] st;
    logic [15:0] len;
    bit          own;
    int unsigned n0;
    int unsigned n1;
    void'($urandom(32'h53d9f7cd));
    own = 1'($urandom());
    reset = 1'b1;
    owner_host = own;
    write_ack_en = 1'b0;
    cfg_len = 16'h0000;
    cfg_len_load = 1'b0;
    #1;
    dcsync_far_i.sys_time = {$urandom(), 32'h0000_1000};
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    foreach (RST_A[i]) begin
      dcsync_far_i.rd_n(own, RST_A[i], RST_N[i], v);
      `CHK(v, 64'h0)
    end
    len = 16'($urandom_range(6, 1));
    @(posedge clock);
    cfg_len <= len;
    cfg_len_load <= 1'b1;
    @(posedge clock);
    cfg_len_load <= 1'b0;
    dcsync_far_i.rd_n(own, dcsync_pkg::ADDR_LEN_LO, 2, v);
    `CHK(v[15:0], len)
    // Writer outside ownership is dropped
    dcsync_far_i.wr_n(!own, dcsync_pkg::ADDR_ACT, 64'h06, 1);
    dcsync_far_i.rd_n(own, dcsync_pkg::ADDR_ACT, 1, v);
    `CHK(v, 64'h0)
    // Cyclic run with both outputs
    dcsync_far_i.wr_n(own, dcsync_pkg::ADDR_CYC0, 64'd800, 4);
    dcsync_far_i.wr_n(own, dcsync_pkg::ADDR_CYC1, 64'd200, 4);
    st = sys_time + 64'd1600;
    dcsync_far_i.wr_n(own, dcsync_pkg::ADDR_START, st, 8);
    dcsync_far_i.frame();
    dcsync_far_i.wr_n(own, dcsync_pkg::ADDR_ACT, 64'h27, 1);
    dcsync_far_i.rd_n(own, dcsync_pkg::ADDR_ACT_STAT, 1, v);
    `CHK(v, 64'h03)
    wait_rise(0, 2);
    `CHK(last_rise[0] - prev_rise[0], 100)
    wait_rise(1, 2);
    `CHK(last_rise[1] - last_rise[0], 25)
    `CHK(last_run[0], exp_run(len))
    `CHK(app_evt_req, 2'b11)
    // Start time write while active is refused
    dcsync_far_i.wr_n(own, dcsync_pkg::ADDR_START, 64'hff, 1);
    dcsync_far_i.frame();
    dcsync_far_i.rd_n(own, dcsync_pkg::ADDR_START, 8, v);
    `CHK(v, st + 64'd1600)
    dcsync_far_i.rd_n(own, dcsync_pkg::ADDR_NEXT1, 8, v);
    `CHK(v, st + 64'd1800)
    dcsync_far_i.rd_n(own, dcsync_pkg::ADDR_ACT_STAT, 1, v);
    `CHK(v, 64'h00)
    dcsync_far_i.wr_n(own, dcsync_pkg::ADDR_ACT, 64'h00, 1);
    n0 = rise_cnt[0];
    repeat (150) @(posedge clock);
    `CHK(rise_cnt[0], n0)
    // Single shot, auto-activation with 32-bit start extended
    dcsync_far_i.wr_n(own, dcsync_pkg::ADDR_CYC0, 64'd0, 4);
    dcsync_far_i.wr_n(own, dcsync_pkg::ADDR_ACT, 64'h1a, 1);
    st = sys_time + 64'd400;
    n0 = rise_cnt[0];
    n1 = rise_cnt[1];
    dcsync_far_i.wr_n(own, dcsync_pkg::ADDR_START, st, 4);
    dcsync_far_i.frame();
    dcsync_far_i.rd_n(own, dcsync_pkg::ADDR_ACT, 1, v);
    `CHK(v, 64'h1b)
    dcsync_far_i.rd_n(own, dcsync_pkg::ADDR_START + 16'd4, 4, v);
    `CHK(v[31:0], st[63:32])
    repeat (200) @(posedge clock);
    #1;
    `CHK(rise_cnt[0] - n0, 1)
    `CHK(rise_cnt[1], n1)
    // Far future start with check on fires at once
    dcsync_far_i.wr_n(own, dcsync_pkg::ADDR_ACT, 64'h00, 1);
    st = sys_time + 64'h1_0000_0000;
    dcsync_far_i.wr_n(own, dcsync_pkg::ADDR_START, st, 8);
    dcsync_far_i.frame();
    n0 = rise_cnt[0];
    dcsync_far_i.wr_n(own, dcsync_pkg::ADDR_ACT, 64'h63, 1);
    repeat (4) @(posedge clock);
    #1;
    `CHK(rise_cnt[0] - n0, 1)
    dcsync_far_i.rd_n(own, dcsync_pkg::ADDR_ACT_STAT, 1, v);
    `CHK(v[2], 1'b1)
    // Debug pulse on the secondary output only
    dcsync_far_i.wr_n(own, dcsync_pkg::ADDR_ACT, 64'h00, 1);
    n0 = rise_cnt[0];
    n1 = rise_cnt[1];
    dcsync_far_i.wr_n(own, dcsync_pkg::ADDR_ACT, 64'h84, 1);
    repeat (4) @(posedge clock);
    #1;
    `CHK(rise_cnt[1] - n1, 1)
    `CHK(rise_cnt[0], n0)
    dcsync_far_i.rd_n(own, dcsync_pkg::ADDR_ACT, 1, v);
    `CHK(v, 64'h04)
    // Acknowledge mode: outputs hold until host acknowledge
    @(posedge clock);
    cfg_len <= 16'h0000;
    cfg_len_load <= 1'b1;
    @(posedge clock);
    cfg_len_load <= 1'b0;
    dcsync_far_i.wr_n(own, dcsync_pkg::ADDR_ACT, 64'h86, 1);
    repeat (30) @(posedge clock);
    #1;
    `CHK(sync_out, 2'b11)
    dcsync_far_i.rd_n(1'b0, dcsync_pkg::ADDR_STAT0, 1, v);
    `CHK(app_evt_req, 2'b11)
    dcsync_far_i.wr_n(1'b1, dcsync_pkg::ADDR_STAT0, 64'h00, 1);
    `CHK(app_evt_req, 2'b11)
    dcsync_far_i.rd_n(1'b1, dcsync_pkg::ADDR_STAT0, 1, v);
    repeat (2) @(posedge clock);
    #1;
    `CHK(app_evt_req, 2'b10)
    `CHK(sync_out, 2'b10)
    @(posedge clock);
    write_ack_en <= 1'b1;
    dcsync_far_i.wr_n(1'b1, dcsync_pkg::ADDR_STAT1, 64'h5a, 1);
    repeat (2) @(posedge clock);
    #1;
    `CHK(app_evt_req, 2'b00)
    `CHK(sync_out, 2'b00)
    conclude();
  end
endmodule
